// ---- logic/dac_write_map.svh ----
// Constants for the serial converter write port: frame layout, reset
// values and link timing. Assumes a 100 MHz system clock.
`ifndef DAC_WRITE_MAP_SVH
`define DAC_WRITE_MAP_SVH

`define FRAME_BITS       5'd24
`define CODE_LSB         0
`define CODE_MSB         15
`define MODE_LSB         16
`define MODE_MSB         17
`define CODE_ZERO        16'h0000
`define CODE_MID         16'h8000
`define SYNC_HIGH_NS     33
`define CLK_PERIOD_NS    10
`define SYNC_HIGH_CYC    ((`SYNC_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- logic/dac_write_pkg.sv ----
// Types for the serial converter write port.
// Assumes the map header supplies all numeric constants.
package dac_write_pkg;

   // Operating mode taken from the two mode bits of a frame.
   typedef enum logic [1:0] {
      MODE_NORMAL  = 2'h0,
      MODE_PD_1K   = 2'h1,
      MODE_PD_100K = 2'h2,
      MODE_PD_HIZ  = 2'h3
   } op_mode_e;

   // Receiver states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } rx_state_e;

endpackage : dac_write_pkg

// ---- logic/dac_write_port.sv ----
// Receive-only three-wire write port of a 16-bit voltage-output converter.
// Assumes frame sync, shift clock and data arrive asynchronously and are
// sampled by MCLK_I, which must run well above twice the shift clock rate.
//
// Operation
// RQ1: Frame opens when frame sync goes low.
// RQ2: Shift one data bit per falling clock.
// RQ3: Execute frame on the 24th falling edge.
// RQ4: Sync may stay low or rise after frame.
// RQ5: Sync high 33 ns; new frame on fall.
// RQ6: Master may idle sync low between frames.
// RQ7: MSB first: six ignored, two mode, sixteen code.
// RQ8: Code is straight binary 0 to 65535.
// RQ9: Master keeps shift clock at most 30 MHz.
// RQ10: Early sync rise discards the frame.
// RQ11: Mode bits select normal or power-down kind.
// RQ12: Power-up code held until first frame.
// RQ13: Power-down leaves stored code unchanged.
// RQ14: Extra clocks ignored until sync re-falls.
`timescale 1ns/1ps

`include "dac_write_map.svh"

module dac_write_port #(
   parameter logic MIDSCALE_AT_RESET = 1'b0
) (
   // System clock and reset.
   input  wire logic        MCLK_I,
   input  wire logic        RST_I,
   // Serial link pins.
   input  wire logic        SYNC_N_I,
   input  wire logic        SCLK_I,
   input  wire logic        DIN_I,
   // Converter state.
   output logic [15:0]      CODE_O,
   output logic [1:0]       MODE_O,
   output logic             POWER_DOWN_O,
   output logic             UPDATE_O,
   output logic             ABORT_O
);

   // Two-flop synchronisers for the three pins.
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic       sclk_prev_reg;
   logic       sync_n_prev_reg;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         sync1_reg       <= 3'h7;
         sync2_reg       <= 3'h7;
         sclk_prev_reg   <= 1'b1;
         sync_n_prev_reg <= 1'b1;
      end else begin
         sync1_reg       <= {SYNC_N_I, SCLK_I, DIN_I};
         sync2_reg       <= sync1_reg;
         sclk_prev_reg   <= sync2_reg[1];
         sync_n_prev_reg <= sync2_reg[2];
      end
   end

   logic sync_n_s;
   logic sclk_s;
   logic din_s;
   logic sclk_fall;
   logic sync_fall;

   // Edge detection on the second flop only.
   assign sync_n_s  = sync2_reg[2];
   assign sclk_s    = sync2_reg[1];
   assign din_s     = sync2_reg[0];
   assign sclk_fall = sclk_prev_reg & ~sclk_s;
   assign sync_fall = sync_n_prev_reg & ~sync_n_s;

   // Receiver state.
   dac_write_pkg::rx_state_e state_reg, state_next;
   logic [23:0] shift_reg, shift_next;
   logic [4:0]  count_reg, count_next;
   logic [15:0] code_reg, code_next;
   logic [1:0]  mode_reg, mode_next;
   logic        update_reg, update_next;
   logic        abort_reg, abort_next;
   logic [23:0] frame_full;

   // The final bit is merged combinationally so execution happens on the
   // very sample of the 24th falling edge.
   assign frame_full = {shift_reg[22:0], din_s}; // [RQ7]

   // Next-state logic for framing, shifting and execution.
   always_comb begin
      state_next  = state_reg;
      shift_next  = shift_reg;
      count_next  = count_reg;
      code_next   = code_reg;
      mode_next   = mode_reg;
      update_next = 1'b0;
      abort_next  = 1'b0;
      unique case (state_reg)
         dac_write_pkg::ST_IDLE: begin
            if (sync_fall) begin // [RQ1] [RQ5]
               state_next = dac_write_pkg::ST_SHIFT;
               shift_next = 24'h000000;
               count_next = 5'd0;
            end
         end
         dac_write_pkg::ST_SHIFT: begin
            if (sync_n_s) begin
               // Early rise: frame is thrown away, code and mode untouched, ABORT_O pulsed.
               state_next = dac_write_pkg::ST_IDLE; // [RQ10]
               shift_next = 24'h000000;
               count_next = 5'd0;
               abort_next = 1'b1;
            end else if (sclk_fall) begin
               shift_next = frame_full; // [RQ2]
               count_next = count_reg + 5'd1;
               if (count_reg == `FRAME_BITS - 5'd1) begin // [RQ3]
                  // A power-down frame leaves the stored code alone; the normal frame
                  // that ends power-down loads the code that it carries.
                  if (frame_full[`MODE_MSB:`MODE_LSB] == 2'h0) begin
                     code_next = frame_full[`CODE_MSB:`CODE_LSB]; // [RQ8]
                  end else begin
                     code_next = code_reg; // [RQ13]
                  end
                  mode_next   = frame_full[`MODE_MSB:`MODE_LSB]; // [RQ11]
                  update_next = 1'b1;
                  state_next  = dac_write_pkg::ST_DONE;
               end
            end
         end
         dac_write_pkg::ST_DONE: begin
            // Shift clock edges are ignored until sync rises.
            if (sync_n_s) begin // [RQ14] [RQ4]
               state_next = dac_write_pkg::ST_IDLE;
               count_next = 5'd0;
            end
         end
         default: begin
            state_next = dac_write_pkg::ST_IDLE;
         end
      endcase
   end

   // Registers for the receiver; reset presets the output code.
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         state_reg  <= dac_write_pkg::ST_IDLE;
         shift_reg  <= 24'h000000;
         count_reg  <= 5'd0;
         code_reg   <= MIDSCALE_AT_RESET ? `CODE_MID : `CODE_ZERO; // [RQ12]
         mode_reg   <= 2'h0;
         update_reg <= 1'b0;
         abort_reg  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         shift_reg  <= shift_next;
         count_reg  <= count_next;
         code_reg   <= code_next;
         mode_reg   <= mode_next;
         update_reg <= update_next;
         abort_reg  <= abort_next;
      end
   end

   // Outputs straight from registers; POWER_DOWN_O is decoded from mode_reg.
   assign CODE_O       = code_reg;
   assign MODE_O       = mode_reg;
   assign POWER_DOWN_O = (mode_reg != 2'h0); // [RQ11]
   assign UPDATE_O     = update_reg;
   assign ABORT_O      = abort_reg;

   // Checks. The sequences name the samples at which a frame ends.
   // The 24th sampled falling edge while the frame is still open.
   sequence s_exec;
      state_reg == dac_write_pkg::ST_SHIFT && !sync_n_s && sclk_fall &&
         count_reg == `FRAME_BITS - 5'd1;
   endsequence

   // Execution of a frame whose mode field asks for normal operation.
   sequence s_exec_normal;
      state_reg == dac_write_pkg::ST_SHIFT && !sync_n_s && sclk_fall &&
         count_reg == `FRAME_BITS - 5'd1 &&
         frame_full[`MODE_MSB:`MODE_LSB] == 2'h0;
   endsequence

   // Execution of a frame whose mode field asks for a power-down mode.
   sequence s_exec_pd;
      state_reg == dac_write_pkg::ST_SHIFT && !sync_n_s && sclk_fall &&
         count_reg == `FRAME_BITS - 5'd1 &&
         frame_full[`MODE_MSB:`MODE_LSB] != 2'h0;
   endsequence

   // Sync seen high while bits are still being gathered.
   sequence s_cut;
      state_reg == dac_write_pkg::ST_SHIFT && sync_n_s;
   endsequence

   chk_exec_loads: assert property ( // [RQ3]
      @(posedge MCLK_I) disable iff (RST_I)
      s_exec_normal |=> UPDATE_O &&
         CODE_O == $past(frame_full[`CODE_MSB:`CODE_LSB]))
      else $error("Frame executed without loading code.");

   chk_pd_keeps_code: assert property ( // [RQ13]
      @(posedge MCLK_I) disable iff (RST_I)
      s_exec_pd |=> UPDATE_O && $stable(CODE_O))
      else $error("Power-down frame changed the stored code.");

   chk_mode_load: assert property ( // [RQ11]
      @(posedge MCLK_I) disable iff (RST_I)
      s_exec |=> MODE_O == $past(frame_full[`MODE_MSB:`MODE_LSB]))
      else $error("Mode bits not taken from frame.");

   chk_abort_hold: assert property ( // [RQ10]
      @(posedge MCLK_I) disable iff (RST_I)
      s_cut |=> ABORT_O && $stable(CODE_O) && $stable(MODE_O))
      else $error("Aborted frame changed converter state.");

   chk_no_update_idle: assert property ( // [RQ1]
      @(posedge MCLK_I) disable iff (RST_I)
      UPDATE_O |-> $past(state_reg) == dac_write_pkg::ST_SHIFT)
      else $error("Update outside an open frame.");

   chk_done_ignores: assert property ( // [RQ14]
      @(posedge MCLK_I) disable iff (RST_I)
      (state_reg == dac_write_pkg::ST_DONE) |=> !UPDATE_O && $stable(CODE_O))
      else $error("Code changed after frame completion.");

   chk_open_on_fall: assert property ( // [RQ1]
      @(posedge MCLK_I) disable iff (RST_I)
      (state_reg == dac_write_pkg::ST_IDLE && sync_fall) |=>
         state_reg == dac_write_pkg::ST_SHIFT && count_reg == 5'd0)
      else $error("Frame did not open on sync fall.");

   chk_idle_waits: assert property ( // [RQ5]
      @(posedge MCLK_I) disable iff (RST_I)
      (state_reg == dac_write_pkg::ST_IDLE && !sync_fall) |=>
         state_reg == dac_write_pkg::ST_IDLE)
      else $error("Frame opened without a sync fall.");

   chk_shift_bit: assert property ( // [RQ2]
      @(posedge MCLK_I) disable iff (RST_I)
      (state_reg == dac_write_pkg::ST_SHIFT && !sync_n_s && sclk_fall) |=>
         shift_reg[0] == $past(din_s) &&
         count_reg == $past(count_reg) + 5'd1)
      else $error("Bit not shifted on falling clock.");

   chk_code_stable: assert property ( // [RQ12]
      @(posedge MCLK_I) disable iff (RST_I)
      !UPDATE_O |-> CODE_O == $past(CODE_O))
      else $error("Code changed without an update.");

endmodule : dac_write_port

// ---- dv/serial_master.sv ----
// Serial master model that writes frames into the converter write port.
// Assumes the port samples data on falling shift clock edges.
`timescale 1ns/1ps

module serial_master (
   // Link pins.
   output logic SYNC_N_O,
   output logic SCLK_O,
   output logic DIN_O
);
   // The shift clock idles high and stands still outside frames.
   initial begin
      SYNC_N_O = 1'b1;
      SCLK_O   = 1'b1;
      DIN_O    = 1'b0;
   end

   // Sends n bits MSB first from w[31]; idle keeps sync low when stop is 0.
   task automatic send(input logic [31:0] w, input int n, input bit stop);
      SYNC_N_O = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         DIN_O = w[31-i];
         #80 SCLK_O = 1'b0; // A 160 ns period stays under 30 MHz.
         #80 SCLK_O = 1'b1;
      end
      DIN_O = ~DIN_O;
      if (!stop) begin
         #400;
      end
      SYNC_N_O = 1'b1;
      #40; // Sync stays high over 33 ns before any next frame.
   endtask : send
endmodule : serial_master

// ---- dv/testbench.sv ----
// Self-checking bench for the converter write port.
// Assumes the serial master model drives all three link pins.
`timescale 1ns/1ps

module testbench;
   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   logic        sync_n, sclk, din, pd, upd, abt;
   logic [15:0] code;
   logic [1:0]  mode;
   int          failures = 0, compares = 0, cyc = 0;
   int          n_upd = 0, n_abt = 0, u0, a0;

   always #5 mclk = ~mclk;

   dac_write_port dac_write_port_inst (.MCLK_I(mclk), .RST_I(rst),
      .SYNC_N_I(sync_n), .SCLK_I(sclk), .DIN_I(din), .CODE_O(code),
      .MODE_O(mode), .POWER_DOWN_O(pd), .UPDATE_O(upd), .ABORT_O(abt));
   serial_master serial_master_inst (.SYNC_N_O(sync_n), .SCLK_O(sclk),
      .DIN_O(din));

   // Pulses stand one cycle, so counting per edge counts each once.
   always @(posedge mclk) begin
      n_upd <= n_upd + int'(upd === 1'b1);
      n_abt <= n_abt + int'(abt === 1'b1);
      cyc <= cyc + 1;
   end

   // Compares outputs and pulse counts taken since the last mark.
   task automatic chk(input logic [18:0] exp, input int eu, input int ea);
      compares++;
      if ({pd, mode, code} !== exp || n_upd - u0 != eu ||
          n_abt - a0 != ea) begin
         $display("BAD t=%0t got %h/%0d/%0d exp %h/%0d/%0d", $time,
            {pd, mode, code}, n_upd - u0, n_abt - a0, exp, eu, ea);
         failures++;
      end
   endtask : chk

   task automatic frame(input logic [31:0] w, input int n, input bit stop);
      @(posedge mclk);
      #1;
      u0 = n_upd;
      a0 = n_abt;
      serial_master_inst.send(w, n, stop);
   endtask : frame

   // Every mode code; power-down frames carry a new code that must not land.
   task automatic test_modes();
      logic [1:0]  m [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
      logic [15:0] c [5] = '{16'hffff, 16'h1234, 16'h5678, 16'h9abc,
                             16'h0001};
      logic [15:0] k [5] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff,
                             16'h0001};
      for (int i = 0; i < 5; i++) begin
         frame({6'h3f, m[i], c[i], 8'h00}, 24, 1'b1);
         chk({m[i] != 2'h0, m[i], k[i]}, 1, 0);
      end
      $display("test modes done");
   endtask : test_modes

   // A frame cut at 23 bits is discarded whole.
   task automatic test_abort();
      frame({6'h00, 2'h3, 16'h5a5a, 8'h00}, 23, 1'b1);
      chk({3'b000, 16'h0001}, 0, 1);
      $display("test abort done");
   endtask : test_abort

   // Extra clocks after the 24th edge with sync idling low change nothing.
   task automatic test_extra();
      frame({6'h00, 2'h0, 16'h8000, 8'h00}, 26, 1'b0);
      chk({3'b000, 16'h8000}, 1, 0);
      frame({6'h15, 2'h0, 16'h7ffe, 8'h00}, 24, 1'b1);
      chk({3'b000, 16'h7ffe}, 1, 0);
      $display("test extra done");
   endtask : test_extra

   // A reset in mid-run brings back zero scale and normal mode, and the
   // port then takes a power-down frame without loading its code.
   task automatic test_reset();
      @(posedge mclk);
      #1 rst = 1'b1;
      repeat (4) @(posedge mclk);
      #1 rst = 1'b0;
      u0 = n_upd;
      a0 = n_abt;
      chk(19'h00000, 0, 0);
      frame({6'h00, 2'h1, 16'h4321, 8'h00}, 24, 1'b1);
      chk({3'b101, 16'h0000}, 1, 0);
      $display("test reset done");
   endtask : test_reset

   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // Reset for 20 cycles, then the scenarios in order under a cycle
   // ceiling; the run needs about 3700 cycles, so 10000 means a hang.
   initial begin
      repeat (20) @(posedge mclk);
      #1 rst = 1'b0;
      u0 = n_upd;
      a0 = n_abt;
      chk(19'h00000, 0, 0);
      fork
         begin
            test_modes();
            test_abort();
            test_extra();
            test_reset();
         end
         begin
            wait (cyc >= 10000);
            $display("BAD t=%0t timeout", $time);
            failures++;
         end
      join_any
      end_of_test();
   end
endmodule : testbench
